//--- hw/mcu_reset_controller.sv
// Function
// - while reset holds, I/O registers take initial values; release starts fetch at vector.
// - port pins reset at once, asynchronously, on supply or pin reset; watchdog and droop act through their registered pulses.
// - after all sources clear, internal reset stretched by fuse-selected delay counter.
// - exactly four sources: supply rise, pin, enabled watchdog, enabled droop detector.
// - pin low beyond minimum width resets ports without clock; core reset waits for the clocked synchroniser; driver holds it that long.
// - pin rising edge starts the delay; processor released when the period expires.
// - supply-rise reset holds below level, crossing starts delay, fall reasserts at once.
// - watchdog time-out gives one-cycle reset pulse; delay starts at its falling edge.
// - enabled droop detector asserts reset once the low level has lasted the minimum period; recovery releases after the delay.
// - level fuse selects droop trigger: low level unprogrammed, high level programmed.
// - droop detector ignores dips shorter than the minimum low-voltage period.
// - watchdog flag set by watchdog reset, cleared by supply rise or zero write.
// - droop flag set by droop reset, cleared by supply rise or zero write.
// - pin flag set by pin reset, cleared by supply rise or zero write.
// - supply flag set by supply-rise reset, cleared only by zero write.
// - bandgap enabled only when droop fuse programmed or bandgap select set.
`timescale 1ns/1ps
`default_nettype none
module mcu_reset_controller #(
  parameter int unsigned STARTUP_BASE = reset_ctrl_pkg::STARTUP_BASE_CYCLES
) (
  input  wire logic                               ref_clk_in,
  input  wire logic                               rst_b_in,
  input  wire logic                               reset_pin_b_in,
  input  wire logic                               watchdog_timeout_in,
  input  wire logic                               watchdog_enable_in,
  input  wire logic                               droop_low_in,
  input  wire logic                               droop_enable_fuse_in,
  input  wire logic                               droop_level_fuse_in,
  input  wire logic [reset_ctrl_pkg::CLOCK_SELECT_FUSES_W-1:0] clock_select_fuses_in,
  input  wire logic [reset_ctrl_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [reset_ctrl_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                               reg_write_in,
  input  wire logic                               reg_read_in,
  output logic      [reset_ctrl_pkg::DATA_W-1:0]  reg_rdata_out,
  output logic                                    port_reset_b_out,
  output logic                                    core_reset_b_out,
  output logic                                    fetch_start_out,
  output logic                                    droop_level_high_out,
  output logic                                    bandgap_enable_out,
  output logic                                    comparator_bandgap_select_out
);
  import reset_ctrl_pkg::*;

  typedef struct packed {
    logic                     pin_s1;
    logic                     pin_s2;
    logic                     drp_s1;
    logic                     drp_s2;
    logic [CLOCK_SELECT_FUSES_W+1:0]       fuse_s1;
    logic [CLOCK_SELECT_FUSES_W+1:0]       fuse_s2;
    logic                     wd_prev;
    logic                     wd_pulse;
    logic [DROOP_CNT_W-1:0]   drp_cnt;
    logic                     drp_trig;
    seq_state_t               state;
    logic [STARTUP_CNT_W-1:0] cnt;
    logic                     core_run;
    logic                     fetch;
    logic [FLAGS_W-1:0]       flags;
    logic                     bg_sel;
    logic                     bg_en;
    logic [DATA_W-1:0]        rdata;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RESET = '{
    pin_s1:   1'b1,
    pin_s2:   1'b1,
    drp_s1:   1'b0,
    drp_s2:   1'b0,
    fuse_s1:  '0,
    fuse_s2:  '0,
    wd_prev:  1'b0,
    wd_pulse: 1'b0,
    drp_cnt:  '0,
    drp_trig: 1'b0,
    state:    ST_STRETCH,
    cnt:      '0,
    core_run: 1'b0,
    fetch:    1'b0,
    flags:    FLAGS_RESET,
    bg_sel:   BG_SEL_RESET,
    bg_en:    1'b0,
    rdata:    '0
  };

  function automatic logic [STARTUP_CNT_W-1:0] startup_limit(input logic [CLOCK_SELECT_FUSES_W-1:0] sel);
    logic [STARTUP_CNT_W-1:0] base;
    base = STARTUP_CNT_W'(STARTUP_BASE);
    return base << sel;
  endfunction

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic                     fuse_droop_en;
  logic                     fuse_level;
  logic [CLOCK_SELECT_FUSES_W-1:0]       fuse_clock_select_fuses;
  logic                     src_active;
  logic [STARTUP_CNT_W-1:0] limit;
  logic                     flags_wr;
  logic                     cmp_wr;

  assign fuse_droop_en = s_q.fuse_s2[CLOCK_SELECT_FUSES_W+1];
  assign fuse_level    = s_q.fuse_s2[CLOCK_SELECT_FUSES_W];
  assign fuse_clock_select_fuses    = s_q.fuse_s2[CLOCK_SELECT_FUSES_W-1:0];
  assign limit         = startup_limit(fuse_clock_select_fuses);
  assign flags_wr      = reg_write_in && (reg_addr_in == FLAGS_OFFSET);
  assign cmp_wr        = reg_write_in && (reg_addr_in == CMP_CTRL_OFFSET);
  // supply rise is rst_b_in itself; the other three sources gathered here
  assign src_active    = !s_q.pin_s2 || s_q.wd_pulse || s_q.drp_trig;

  // raw pin and supply feed the port reset directly: it must act with no clock running,
  // so this path deliberately bypasses the synchroniser
  assign port_reset_b_out = rst_b_in && reset_pin_b_in && !s_q.wd_pulse && !s_q.drp_trig;

  always_comb
  begin
    s_d = s_q;
    s_d.pin_s1  = reset_pin_b_in;
    s_d.pin_s2  = s_q.pin_s1;
    s_d.drp_s1  = droop_low_in;
    s_d.drp_s2  = s_q.drp_s1;
    s_d.fuse_s1 = {droop_enable_fuse_in, droop_level_fuse_in, clock_select_fuses_in};
    s_d.fuse_s2 = s_q.fuse_s1;

    // one-cycle pulse from the time-out edge, only while the watchdog runs
    s_d.wd_prev  = watchdog_timeout_in;
    s_d.wd_pulse = watchdog_timeout_in && !s_q.wd_prev && watchdog_enable_in;

    // droop qualification: the low level must persist before it counts
    if (fuse_droop_en && s_q.drp_s2)
    begin
      if (s_q.drp_cnt != DROOP_CNT_W'(DROOP_MIN_CYCLES))
      begin
        s_d.drp_cnt = s_q.drp_cnt + 1'b1;
      end
      if (s_q.drp_cnt == DROOP_CNT_W'(DROOP_MIN_CYCLES - 1))
      begin
        s_d.drp_trig = 1'b1;
      end
    end
    else
    begin
      s_d.drp_cnt  = '0;
      s_d.drp_trig = 1'b0;
    end

    // sequencer
    s_d.fetch = 1'b0;
    case (s_q.state)
      ST_HOLD:
      begin
        s_d.cnt = '0;
        if (!src_active)
        begin
          s_d.state = ST_STRETCH;
        end
      end
      ST_STRETCH:
      begin
        if (src_active)
        begin
          s_d.state = ST_HOLD;
          s_d.cnt   = '0;
        end
        else if (s_q.cnt >= limit - 1'b1)
        begin
          s_d.state = ST_RUN;
          s_d.fetch = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_RUN:
      begin
        if (src_active)
        begin
          s_d.state = ST_HOLD;
          s_d.cnt   = '0;
        end
      end
      default:
      begin
        s_d.state = ST_HOLD;
        s_d.cnt   = '0;
      end
    endcase
    s_d.core_run = (s_d.state == ST_RUN);

    // cause flags: zero write clears, one write keeps, hardware set wins
    if (flags_wr)
    begin
      s_d.flags = s_q.flags & reg_wdata_in[FLAGS_W-1:0];
    end
    if (s_q.wd_pulse)
    begin
      s_d.flags[WD_FLAG_BIT] = 1'b1;
    end
    if (s_q.drp_trig)
    begin
      s_d.flags[DROOP_FLAG_BIT] = 1'b1;
    end
    if (!s_q.pin_s2)
    begin
      s_d.flags[PIN_FLAG_BIT] = 1'b1;
    end

    // comparator control returns to its initial value under any internal reset
    if (!s_q.core_run)
    begin
      s_d.bg_sel = BG_SEL_RESET;
    end
    else if (cmp_wr)
    begin
      s_d.bg_sel = reg_wdata_in[BG_SEL_BIT];
    end
    s_d.bg_en = fuse_droop_en || s_q.bg_sel;

    // read data stands in the cycle after the strobe only
    s_d.rdata = '0;
    if (reg_read_in)
    begin
      case (reg_addr_in)
        FLAGS_OFFSET:    s_d.rdata[FLAGS_W-1:0] = s_q.flags;
        CMP_CTRL_OFFSET: s_d.rdata[BG_SEL_BIT]  = s_q.bg_sel;
        default:         s_d.rdata = '0;
      endcase
    end
  end

  // supply-rise reset: flags get supply bit set, others cleared; delay starts at release
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out                 = s_q.rdata;
  assign core_reset_b_out              = s_q.core_run;
  assign fetch_start_out               = s_q.fetch;
  assign droop_level_high_out          = fuse_level;
  assign bandgap_enable_out            = s_q.bg_en;
  assign comparator_bandgap_select_out = s_q.bg_sel;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence wd_edge_s;
    $rose(watchdog_timeout_in) && watchdog_enable_in;
  endsequence
  sequence pulse_once_s;
    s_q.wd_pulse ##1 !s_q.wd_pulse;
  endsequence
  sequence quiet_s;
    s_q.pin_s2 && !s_q.drp_trig;
  endsequence

  a_wd_pulse_len: assert property (wd_edge_s |=> pulse_once_s)
    else $error("watchdog pulse not one cycle");
  a_wd_delay_start: assert property (s_q.wd_pulse && s_q.pin_s2 && !s_q.drp_trig
      ##1 quiet_s |=> s_q.state == ST_STRETCH && s_q.cnt == '0)
    else $error("delay not started after watchdog pulse");
  a_pin_holds: assert property (!s_q.pin_s2 |=> s_q.state == ST_HOLD && !core_reset_b_out)
    else $error("pin low did not hold reset");
  a_port_async: assert property (!reset_pin_b_in |-> !port_reset_b_out)
    else $error("port reset not following pin");
  a_release_len: assert property ($rose(s_q.core_run) |-> $past(s_q.cnt) == limit - 1'b1)
    else $error("release before delay expired");
  a_fetch_pulse: assert property (fetch_start_out |-> core_reset_b_out && $past(!core_reset_b_out)
      ##1 !fetch_start_out)
    else $error("fetch start not at release");
  a_droop_filter: assert property ($rose(s_q.drp_trig) |->
      $past(s_q.drp_cnt) == DROOP_CNT_W'(DROOP_MIN_CYCLES - 1))
    else $error("droop trigger before minimum period");
  a_droop_reset: assert property ($rose(s_q.drp_trig) |=> s_q.state == ST_HOLD
      && s_q.flags[DROOP_FLAG_BIT])
    else $error("droop did not reset and flag");
  a_flag_keep_one: assert property (flags_wr && reg_wdata_in[FLAGS_W-1:0] == 4'hF
      |=> s_q.flags == $past(s_q.flags) || s_q.flags != $past(s_q.flags)
      && ($past(s_q.wd_pulse) || $past(s_q.drp_trig) || !$past(s_q.pin_s2)))
    else $error("one write changed a flag");
  a_flag_clear: assert property (flags_wr && !reg_wdata_in[SUPPLY_FLAG_BIT] |=> !s_q.flags[SUPPLY_FLAG_BIT])
    else $error("zero write did not clear supply flag");
  a_wd_flag_set: assert property (s_q.wd_pulse |=> s_q.flags[WD_FLAG_BIT])
    else $error("watchdog flag not set");
  a_pin_flag_set: assert property (!s_q.pin_s2 |=> s_q.flags[PIN_FLAG_BIT])
    else $error("pin flag not set");
  a_bandgap_en: assert property (##1 bandgap_enable_out == $past(fuse_droop_en || s_q.bg_sel))
    else $error("bandgap enable wrong");

endmodule
`default_nettype wire

//--- shared/reset_ctrl_pkg.sv
package reset_ctrl_pkg;

  // clock rate and droop qualification time
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned DROOP_MIN_US     = 2;
  localparam int unsigned DROOP_MIN_CYCLES = DROOP_MIN_US * CLK_MHZ;
  localparam int unsigned DROOP_CNT_W      = $clog2(DROOP_MIN_CYCLES + 1);

  // start-up delay: base count shifted left by the clock-select fuse code
  localparam int unsigned STARTUP_BASE_CYCLES = 4096;
  localparam int unsigned CLOCK_SELECT_FUSES_W             = 4;
  localparam int unsigned STARTUP_CNT_W       = 28;

  // register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] FLAGS_OFFSET    = 4'h0;
  localparam logic [ADDR_W-1:0] CMP_CTRL_OFFSET = 4'h1;

  // reset_cause_flags field positions
  localparam int unsigned SUPPLY_FLAG_BIT = 0;
  localparam int unsigned PIN_FLAG_BIT    = 1;
  localparam int unsigned DROOP_FLAG_BIT  = 2;
  localparam int unsigned WD_FLAG_BIT     = 3;
  localparam int unsigned FLAGS_W         = 4;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 4'h1;

  // comparator_control_register field positions
  localparam int unsigned BG_SEL_BIT   = 0;
  localparam logic        BG_SEL_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_STRETCH,
    ST_RUN
  } seq_state_t;

endpackage

//--- verification/reset_sources_model.sv
`timescale 1ns/1ps
`default_nettype none
module reset_sources_model (
  input  wire logic ref_clk_in,
  output logic      reset_pin_b_out,
  output logic      watchdog_timeout_out,
  output logic      droop_low_out
);
  initial
  begin
    reset_pin_b_out = 1'b1;
    watchdog_timeout_out = 1'b0;
    droop_low_out = 1'b0;
  end
  // pin held far past the sync depth, shorter pulses carry no promise
  task automatic pin_low(input int n);
    @(posedge ref_clk_in) reset_pin_b_out <= 1'b0;
    repeat (n) @(posedge ref_clk_in);
    reset_pin_b_out <= 1'b1;
  endtask
  task automatic wd_fire();
    @(posedge ref_clk_in) watchdog_timeout_out <= 1'b1;
    @(posedge ref_clk_in) watchdog_timeout_out <= 1'b0;
  endtask
  task automatic droop(input int n);
    @(posedge ref_clk_in) droop_low_out <= 1'b1;
    repeat (n) @(posedge ref_clk_in);
    droop_low_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import reset_ctrl_pkg::*;
  localparam int unsigned BASE = 4;
  logic       clk, rst_b, pin_b, wd_to, wd_en, dlow, d_en, d_lvl, wr_s, rd_s;
  logic       port_b, core_b, fetch, lvl_hi, bg_en, bg_sel;
  logic [3:0] clock_select_fuses, addr;
  logic [7:0] wdata, rdata;
  int         n_fail, cmp_count;
  reset_sources_model src_u (.ref_clk_in(clk), .reset_pin_b_out(pin_b), .watchdog_timeout_out(wd_to),
    .droop_low_out(dlow));
  mcu_reset_controller #(.STARTUP_BASE(BASE)) dut_u (.ref_clk_in(clk), .rst_b_in(rst_b),
    .reset_pin_b_in(pin_b), .watchdog_timeout_in(wd_to), .watchdog_enable_in(wd_en),
    .droop_low_in(dlow), .droop_enable_fuse_in(d_en), .droop_level_fuse_in(d_lvl),
    .clock_select_fuses_in(clock_select_fuses), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s),
    .reg_read_in(rd_s), .reg_rdata_out(rdata), .port_reset_b_out(port_b), .core_reset_b_out(core_b),
    .fetch_start_out(fetch), .droop_level_high_out(lvl_hi), .bandgap_enable_out(bg_en),
    .comparator_bandgap_select_out(bg_sel));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // core must stay held at least the stretch count, then fetch must be high as core releases
  task automatic wait_rel();
    int n;
    n = 0;
    // step off the edge so the first sample sees settled outputs
    #1;
    chk({7'h0, core_b}, 8'h00);
    while (core_b !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(n >= BASE && n < 300), 8'h01);
    chk({7'h0, fetch}, 8'h01);
  endtask
  task automatic t_start();
    repeat (16) @(posedge clk);
    chk({6'h0, port_b, core_b}, 8'h00);
    rst_b <= 1'b1;
    wait_rel();
    rchk(FLAGS_OFFSET, 8'h01);
    wr(FLAGS_OFFSET, 8'h00);
    rchk(FLAGS_OFFSET, 8'h00);
    wr(FLAGS_OFFSET, 8'hFF);
    rchk(FLAGS_OFFSET, 8'h00);
    $display("done start");
  endtask
  task automatic t_pin();
    fork
      src_u.pin_low(8);
      begin
        tick(1);
        chk({7'h0, port_b}, 8'h00);
      end
    join
    wait_rel();
    rchk(FLAGS_OFFSET, 8'h02);
    $display("done pin");
  endtask
  task automatic t_wd();
    int n;
    n = 0;
    fork
      src_u.wd_fire();
      repeat (6) tick(1) ;
    join
    chk({7'h0, core_b}, 8'h01);
    wd_en <= 1'b1;
    // short window: core reset must still be held, before the stretch begins, when wait_rel starts counting
    fork
      src_u.wd_fire();
      repeat (3)
      begin
        tick(1);
        n += int'(port_b === 1'b0);
      end
    join
    chk(8'(n), 8'h01);
    wait_rel();
    rchk(FLAGS_OFFSET, 8'h0A);
    $display("done watchdog");
  endtask
  task automatic t_droop();
    d_en <= 1'b1;
    d_lvl <= 1'b1;
    tick(4);
    chk({6'h0, lvl_hi, bg_en}, 8'h03);
    src_u.droop(100);
    tick(4);
    chk({7'h0, core_b}, 8'h01);
    fork
      src_u.droop(600);
      begin
        tick(560);
        chk({7'h0, core_b}, 8'h00);
      end
    join
    wait_rel();
    rchk(FLAGS_OFFSET, 8'h0E);
    d_en <= 1'b0;
    d_lvl <= 1'b0;
    tick(4);
    chk({6'h0, lvl_hi, bg_en}, 8'h00);
    src_u.droop(600);
    tick(4);
    chk({7'h0, core_b}, 8'h01);
    $display("done droop");
  endtask
  task automatic t_bg();
    wr(CMP_CTRL_OFFSET, 8'h01);
    // reference given time to start before anything relies on it
    tick(3);
    chk({6'h0, bg_sel, bg_en}, 8'h03);
    rchk(CMP_CTRL_OFFSET, 8'h01);
    rchk(4'hF, 8'h00);
    wr(CMP_CTRL_OFFSET, 8'h00);
    tick(3);
    chk({6'h0, bg_sel, bg_en}, 8'h00);
    $display("done bandgap");
  endtask
  task automatic t_por();
    @(posedge clk) rst_b <= 1'b0;
    #1 chk({6'h0, port_b, core_b}, 8'h00);
    tick(3);
    rst_b <= 1'b1;
    wait_rel();
    rchk(FLAGS_OFFSET, 8'h01);
    $display("done supply");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    results();
  end
  initial
  begin
    {rst_b, wd_en, d_en, d_lvl, wr_s, rd_s} = '0;
    clock_select_fuses = 4'h0;
    addr = 4'h0;
    wdata = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    t_start();
    t_pin();
    t_wd();
    t_droop();
    t_bg();
    t_por();
    results();
  end
endmodule
`default_nettype wire
